// ===== shared/crvse_pkg.sv
// Package of constants and types for the character-row video scroll engine
package crvse_pkg;

  // ****************************************************************
  // Scroll port map
  // ****************************************************************
  localparam logic [7:0] SCROLL_PORT_ADDR  = 8'hFE;  // Latch write and pace status read
  localparam int         STAT_BUSY_BIT     = 0;      // Timer running flag position
  localparam int         ROW_FIELD_LSB     = 0;      // Starting row field
  localparam int         SHADE_FIELD_LSB   = 4;      // Screen position field
  localparam logic [3:0] ROW_RESET         = 4'h0;   // Row latch after reset
  localparam logic [3:0] SHADE_RESET       = 4'h0;   // Screen position latch after reset

  // ****************************************************************
  // Character and scan geometry
  // ****************************************************************
  localparam logic [3:0] SCAN_TOP          = 4'hF;   // Blank top line count
  localparam logic [3:0] SCAN_LAST         = 4'hB;   // Last line count of a row
  localparam int         SCAN_LINES        = 13;     // Lines per character row
  localparam logic [3:0] DOT_LAST          = 4'h8;   // Nine dots per character
  localparam int         CURSOR_BIT        = 7;      // Cursor marker in memory word

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int         CLK_HZ            = 40000000;             // Core clock rate
  localparam int         CNT_EN_NS         = 600;                  // Counter enable width
  localparam int         CNT_EN_CYC        = CNT_EN_NS * 40 / 1000; // 600 ns in 25 ns cycles
  localparam int         PACE_MS           = 250;                  // Scroll pace one-shot
  localparam int         PACE_CYC          = CLK_HZ / 1000 * PACE_MS;
  localparam int         FLASH_MS          = 500;                  // Flash period
  localparam int         FLASH_HALF_CYC    = CLK_HZ / 1000 * FLASH_MS / 2;

  // ****************************************************************
  // Row sequencing state
  // ****************************************************************
  typedef enum logic [2:0] {
    CRVSE_ST_TOP  = 3'b001,  // Vertical blank, counters preset
    CRVSE_ST_WAIT = 3'b010,  // Window shade counting down
    CRVSE_ST_RUN  = 3'b100   // Row counter advancing
  } crvse_vstate_t;

endpackage

// ===== hdl/crvse_top.sv
// Character-row video generator with hardware scroll and pace timer
`timescale 1ns/10ps
module crvse_top #(
  parameter int PACE_CYCLES  = crvse_pkg::PACE_CYC,       // One-shot length in cycles
  parameter int FLASH_CYCLES = crvse_pkg::FLASH_HALF_CYC  // Flash half period in cycles
) (
  input  wire logic       core_clk,             // Dot clock, 40 MHz
  input  wire logic       sys_rst,              // Asynchronous reset, active high
  input  wire logic       horiz_active,         // Horizontal display window, pin
  input  wire logic       vert_active_n,        // Vertical display active, low, pin
  input  wire logic       flash_option_switch,  // Blink option, pin
  input  wire logic       reverse_video_switch, // Reverse display option, pin
  input  wire logic       ext_blank,            // Other blanking source, pin
  input  wire logic       scroll_port_wr_n,     // Scroll port write strobe, low, pin
  input  wire logic       scroll_port_rd_n,     // Scroll port read strobe, low, pin
  input  wire logic [7:0] cpu_data_in,          // CPU data bus in, pin
  output logic      [7:0] cpu_data_out,         // CPU data bus out
  output logic            cpu_data_oe,          // High while driving the data bus
  output logic      [5:0] char_addr,            // Character position in row
  output logic      [3:0] row_addr,             // Row of display memory
  input  wire logic [7:0] mem_word,             // Display memory data, same clock
  output logic      [6:0] glyph_code,           // Code to glyph lookup
  output logic      [3:0] glyph_line,           // Line to glyph lookup
  input  wire logic [6:0] glyph_dots,           // Glyph lookup dots, same clock
  output logic            load_strobe,          // Per-character load pulse
  output logic            serial_dot_out,       // Raw dot stream
  output logic            video_out,            // Final video
  output logic            shade_blank           // Window shade blank active
);

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  logic [6:0] sync1_q;  // First stage, read only by second
  logic [6:0] sync2_q;  // Second stage
  // Two flops per pin; reset holds strobes and frame idle high, options low
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sync1_q <= 7'h62;
      sync2_q <= 7'h62;
    end else begin
      sync1_q <= {scroll_port_rd_n, scroll_port_wr_n, ext_blank, reverse_video_switch,
                  flash_option_switch, vert_active_n, horiz_active};
      sync2_q <= sync1_q;
    end
  end
  logic h_act, v_act_n, flash_sw, rev_sw, blank_in, wr_n, rd_n;  // Synchronised pins
  assign {rd_n, wr_n, blank_in, rev_sw, flash_sw, v_act_n, h_act} = sync2_q;

  logic [7:0] data_s1_q;  // Data bus first stage
  logic [7:0] data_s2_q;  // Data bus second stage
  // Data bus settles through two flops while the write strobe is held
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      data_s1_q <= 8'h00;
      data_s2_q <= 8'h00;
    end else begin
      data_s1_q <= cpu_data_in;
      data_s2_q <= data_s1_q;
    end
  end

  // ****************************************************************
  // Dot counter and load strobe
  // ****************************************************************
  logic [3:0] dot_q;  // Dot within character
  // Nine-dot character cell; the strobe marks its last dot
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      dot_q <= 4'h0;
    end else if (dot_q == crvse_pkg::DOT_LAST) begin
      dot_q <= 4'h0;
    end else begin
      dot_q <= dot_q + 4'h1;
    end
  end
  assign load_strobe = (dot_q == crvse_pkg::DOT_LAST);

  // ****************************************************************
  // Line end detection and character address
  // ****************************************************************
  logic h_dly_q;  // Previous horizontal active
  // Remembers the line window to find where each line ends
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      h_dly_q <= 1'b0;
    end else begin
      h_dly_q <= h_act;
    end
  end
  logic line_end;  // Falling edge of horizontal active
  assign line_end = h_dly_q & ~h_act;

  // Character position restarts each line so the row is refetched
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      char_addr <= 6'h00;
    end else if (line_end) begin
      char_addr <= 6'h00;
    end else if (load_strobe && h_act) begin
      char_addr <= char_addr + 6'h01;
    end
  end

  // ****************************************************************
  // Scan line counter
  // ****************************************************************
  logic [3:0] scan_q;    // Current scan line
  logic       reload_q;  // Pulse after scan counter reload
  // Thirteen counts per row, parked on the blank top line in vertical blank
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      scan_q   <= crvse_pkg::SCAN_TOP;
      reload_q <= 1'b0;
    end else begin
      reload_q <= 1'b0;
      if (v_act_n) begin
        scan_q <= crvse_pkg::SCAN_TOP;  // Vertical blank starts rows fresh
      end else if (line_end) begin
        if (scan_q == crvse_pkg::SCAN_LAST) begin
          scan_q   <= crvse_pkg::SCAN_TOP;
          reload_q <= 1'b1;
        end else begin
          scan_q <= scan_q + 4'h1;
        end
      end
    end
  end
  assign glyph_line = scan_q;

  // ****************************************************************
  // Count enable window after reload
  // ****************************************************************
  logic [4:0] en_cnt_q;  // Remaining enable cycles
  // Opens the counter enable window right after each reload
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      en_cnt_q <= 5'h00;
    end else if (reload_q) begin
      en_cnt_q <= 5'(crvse_pkg::CNT_EN_CYC);
    end else if (en_cnt_q != 5'h00) begin
      en_cnt_q <= en_cnt_q - 5'h01;
    end
  end
  // The counters move once per window, on its last cycle, so a long
  // window cannot step them twice
  logic cnt_step;  // One step per window
  assign cnt_step = (en_cnt_q == 5'h01);

  // ****************************************************************
  // Scroll latch and pace timer
  // ****************************************************************
  logic wr_dly_q;   // Previous write strobe
  logic [3:0] row_latch_q;    // Starting row
  logic [3:0] shade_latch_q;  // Screen position preset
  logic wr_fall;    // Write strobe assertion
  assign wr_fall = wr_dly_q & ~wr_n;
  // Both presets are taken from the bus when the write strobe falls
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_dly_q      <= 1'b1;
      row_latch_q   <= crvse_pkg::ROW_RESET;
      shade_latch_q <= crvse_pkg::SHADE_RESET;
    end else begin
      wr_dly_q <= wr_n;
      if (wr_fall) begin
        row_latch_q   <= data_s2_q[crvse_pkg::ROW_FIELD_LSB +: 4];
        shade_latch_q <= data_s2_q[crvse_pkg::SHADE_FIELD_LSB +: 4];
      end
    end
  end

  logic [23:0] pace_q;  // One-shot remaining cycles
  // A write restarts the timer even while it is still running
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pace_q <= 24'h000000;
    end else if (wr_fall) begin
      pace_q <= 24'(PACE_CYCLES);
    end else if (pace_q != 24'h000000) begin
      pace_q <= pace_q - 24'h000001;
    end
  end

  // Status read drives bit 0 with the timer state
  // Upper bits read as zero so software can test bit 0 alone
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cpu_data_out <= 8'h00;
    end else begin
      cpu_data_out <= {7'h00, (pace_q != 24'h000000)};
    end
  end
  assign cpu_data_oe = ~rd_n;

  // ****************************************************************
  // Row and window-shade counters
  // ****************************************************************
  crvse_pkg::crvse_vstate_t vst_q;  // Vertical sequencing state
  logic [3:0] shade_q;  // Screen position down-counter
  // Presets held in vertical blank; shade counts rows, then rows advance
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      vst_q    <= crvse_pkg::CRVSE_ST_TOP;
      shade_q  <= crvse_pkg::SHADE_RESET;
      row_addr <= crvse_pkg::ROW_RESET;
    end else begin
      case (vst_q)
        crvse_pkg::CRVSE_ST_TOP: begin
          shade_q  <= shade_latch_q;
          row_addr <= row_latch_q;
          if (!v_act_n) begin
            vst_q <= (shade_latch_q == 4'h0) ? crvse_pkg::CRVSE_ST_RUN
                                             : crvse_pkg::CRVSE_ST_WAIT;
          end
        end
        crvse_pkg::CRVSE_ST_WAIT: begin
          if (v_act_n) begin
            vst_q <= crvse_pkg::CRVSE_ST_TOP;
          end else if (cnt_step) begin
            shade_q <= shade_q - 4'h1;
            if (shade_q == 4'h1) begin
              vst_q <= crvse_pkg::CRVSE_ST_RUN;
            end
          end
        end
        crvse_pkg::CRVSE_ST_RUN: begin
          if (v_act_n) begin
            vst_q <= crvse_pkg::CRVSE_ST_TOP;
          end else if (cnt_step) begin
            row_addr <= row_addr + 4'h1;
          end
        end
        default: begin
          vst_q <= crvse_pkg::CRVSE_ST_TOP;
        end
      endcase
    end
  end
  assign shade_blank = (vst_q != crvse_pkg::CRVSE_ST_RUN);

  // ****************************************************************
  // Character latch and glyph request
  // ****************************************************************
  logic cur_lat_q;  // Cursor mark of latched character
  // Display word taken at each character load
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      glyph_code <= 7'h20;
      cur_lat_q  <= 1'b0;
    end else if (load_strobe) begin
      glyph_code <= mem_word[6:0];
      cur_lat_q  <= mem_word[crvse_pkg::CURSOR_BIT];
    end
  end

  // Lines the lookup leaves dark: top line and unused tail lines
  // Only the top line is forced here; the lookup itself darkens 9 to 11
  logic dark_line;
  assign dark_line = (scan_q == crvse_pkg::SCAN_TOP);  // lookup blanks 9-11

  // ****************************************************************
  // Dot shifter
  // ****************************************************************
  logic [7:0] shift_q;  // Parallel to serial path
  logic       cur_q;    // Cursor flag for shifted character
  // Loads the glyph with a grounded eighth bit, then shifts in zeros
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      shift_q <= 8'h00;
      cur_q   <= 1'b0;
    end else if (load_strobe) begin
      shift_q <= {dark_line ? 7'h00 : glyph_dots, 1'b0};
      cur_q   <= cur_lat_q;
    end else begin
      shift_q <= {shift_q[6:0], 1'b0};
    end
  end
  assign serial_dot_out = shift_q[7];

  // ****************************************************************
  // Flash oscillator
  // ****************************************************************
  logic [23:0] flash_cnt_q;  // Half period count
  logic        flash_q;      // Flash phase
  // Free-running blink source, independent of the option switch
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      flash_cnt_q <= 24'h000000;
      flash_q     <= 1'b0;
    end else if (flash_cnt_q == 24'(FLASH_CYCLES - 1)) begin
      flash_cnt_q <= 24'h000000;
      flash_q     <= ~flash_q;
    end else begin
      flash_cnt_q <= flash_cnt_q + 24'h000001;
    end
  end

  // ****************************************************************
  // Cursor, blanking and reverse video
  // ****************************************************************
  logic blank_d1_q, blank_d2_q;  // Blank delayed two characters
  // Blanking shifted by two characters to line up with the dots
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      blank_d1_q <= 1'b1;
      blank_d2_q <= 1'b1;
    end else if (load_strobe) begin
      blank_d1_q <= ~h_act | v_act_n | blank_in | shade_blank;
      blank_d2_q <= blank_d1_q;
    end
  end

  logic cursor_gate;  // Cursor inversion enable
  assign cursor_gate = cur_q & ~(flash_sw & flash_q);

  // Final video registered from the dot path
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      video_out <= 1'b0;
    end else begin
      video_out <= ((serial_dot_out ^ cursor_gate) & ~blank_d2_q) ^ rev_sw;
    end
  end

endmodule

// ===== tb/crvse_props.sv
// Checker of scan sequencing, scroll presets and the pace status port
`timescale 1ns/10ps
module crvse_props #(
  parameter int PACE_CYCLES  = 100, // One-shot length
  parameter int FLASH_CYCLES = 50   // Flash half period
) (
  input wire logic       core_clk,             // Clock
  input wire logic       sys_rst,              // Reset
  input wire logic       horiz_active,         // Line window
  input wire logic       vert_active_n,        // Frame window
  input wire logic       flash_option_switch,  // Blink option
  input wire logic       reverse_video_switch, // Reverse option
  input wire logic       ext_blank,            // Blank source
  input wire logic       scroll_port_wr_n,     // Write strobe
  input wire logic       scroll_port_rd_n,     // Read strobe
  input wire logic [7:0] cpu_data_in,          // Data in
  input wire logic [7:0] cpu_data_out,         // Data out
  input wire logic       cpu_data_oe,          // Data enable
  input wire logic [5:0] char_addr,            // Position
  input wire logic [3:0] row_addr,             // Row
  input wire logic [7:0] mem_word,             // Memory word
  input wire logic [6:0] glyph_code,           // Code
  input wire logic [3:0] glyph_line,           // Scan line
  input wire logic [6:0] glyph_dots,           // Dots
  input wire logic       load_strobe,          // Load pulse
  input wire logic       serial_dot_out,       // Raw dots
  input wire logic       video_out,            // Video
  input wire logic       shade_blank           // Shade blank
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);

  // ****************************************************************
  // Helper: cycles since the last write strobe fell
  // ****************************************************************
  logic [31:0] since_wr_q; // Saturating age of last write
  logic        wr_n_q;     // Previous write strobe
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      since_wr_q <= 32'h8000_0000;
      wr_n_q     <= 1'b1;
    end else begin
      wr_n_q <= scroll_port_wr_n;
      if (wr_n_q && !scroll_port_wr_n) begin
        since_wr_q <= 32'h0;
      end else if (!since_wr_q[31]) begin
        since_wr_q <= since_wr_q + 32'h1;
      end
    end
  end

  // ****************************************************************
  // Properties
  // ****************************************************************
  sequence s_gap;
    (!load_strobe) [*8] ##1 load_strobe;
  endsequence
  sequence s_busy;
    cpu_data_out[0] [*8];
  endsequence
  property p_load_period;
    load_strobe |-> ##1 s_gap;
  endproperty
  property p_code_latch;
    load_strobe |=> glyph_code == $past(mem_word[6:0]);
  endproperty
  property p_scan_step;
    $changed(glyph_line) |-> (glyph_line == $past(glyph_line) + 4'h1)
      || ($past(glyph_line) == 4'hB && glyph_line == 4'hF);
  endproperty
  property p_scan_range;
    glyph_line < 4'hC || glyph_line == 4'hF;
  endproperty
  property p_stat_zero;
    cpu_data_oe |-> cpu_data_out[7:1] == 7'h00;
  endproperty
  property p_oe_on;
    (!scroll_port_rd_n) [*3] |-> cpu_data_oe;
  endproperty
  property p_oe_off;
    scroll_port_rd_n [*3] |-> !cpu_data_oe;
  endproperty
  property p_pace_start;
    $fell(scroll_port_wr_n) |-> ##[3:5] s_busy;
  endproperty
  property p_pace_end;
    since_wr_q > PACE_CYCLES + 8 |-> !cpu_data_out[0];
  endproperty
  property p_shade_hold;
    vert_active_n [*4] |-> shade_blank;
  endproperty
  property p_row_step;
    !vert_active_n && $past(vert_active_n, 4) == 1'b0 && $changed(row_addr)
      |-> row_addr == $past(row_addr) + 4'h1;
  endproperty
  sequence s_spacers;
    (!serial_dot_out) [*2];
  endsequence
  property p_dot_first;
    load_strobe && glyph_line != 4'hF |=> serial_dot_out == $past(glyph_dots[6]);
  endproperty
  property p_dot_spacer;
    load_strobe |-> ##8 s_spacers;
  endproperty
  property p_char_restart;
    $fell(horiz_active) |-> ##3 char_addr == 6'h00;
  endproperty
  a_load_period: assert property (p_load_period) else $error("load period wrong");
  a_code_latch: assert property (p_code_latch) else $error("code not latched");
  a_scan_step: assert property (p_scan_step) else $error("scan step wrong");
  a_scan_range: assert property (p_scan_range) else $error("scan out of range");
  a_stat_zero: assert property (p_stat_zero) else $error("status high bits set");
  a_oe_on: assert property (p_oe_on) else $error("status not driven");
  a_oe_off: assert property (p_oe_off) else $error("status driven idle");
  a_pace_start: assert property (p_pace_start) else $error("pace not started");
  a_pace_end: assert property (p_pace_end) else $error("pace too long");
  a_shade_hold: assert property (p_shade_hold) else $error("shade not held");
  a_row_step: assert property (p_row_step) else $error("row step wrong");
  a_dot_first: assert property (p_dot_first) else $error("first dot wrong");
  a_dot_spacer: assert property (p_dot_spacer) else $error("spacer dot lit");
  a_char_restart: assert property (p_char_restart) else $error("row not refetched");
endmodule

bind crvse_top crvse_props #(.PACE_CYCLES(PACE_CYCLES), .FLASH_CYCLES(FLASH_CYCLES)) u_props (
  .core_clk(core_clk), .sys_rst(sys_rst), .horiz_active(horiz_active),
  .vert_active_n(vert_active_n), .flash_option_switch(flash_option_switch),
  .reverse_video_switch(reverse_video_switch), .ext_blank(ext_blank),
  .scroll_port_wr_n(scroll_port_wr_n), .scroll_port_rd_n(scroll_port_rd_n),
  .cpu_data_in(cpu_data_in), .cpu_data_out(cpu_data_out), .cpu_data_oe(cpu_data_oe),
  .char_addr(char_addr), .row_addr(row_addr), .mem_word(mem_word),
  .glyph_code(glyph_code), .glyph_line(glyph_line), .glyph_dots(glyph_dots),
  .load_strobe(load_strobe), .serial_dot_out(serial_dot_out), .video_out(video_out),
  .shade_blank(shade_blank)
);

// ===== tb/crvse_mem_model.sv
// Display memory and glyph lookup seen by the engine
`timescale 1ns/10ps
module crvse_mem_model (
  input  wire logic [5:0] char_addr,  // Position in row
  input  wire logic [3:0] row_addr,   // Memory row
  input  wire logic [6:0] glyph_code, // Latched code
  input  wire logic [3:0] glyph_line, // Scan line
  input  wire logic [5:0] cursor_pos, // Cursor position
  output logic      [7:0] mem_word,   // Display word
  output logic      [6:0] glyph_dots  // Line dots
);
  // Code made from row and position, cursor mark on top
  assign mem_word = {char_addr == cursor_pos, row_addr, char_addr[2:0]};
  // Lines 0 to 8 carry dots; 9 to 11 and the top line stay dark
  assign glyph_dots = (glyph_line <= 4'h8) ? (glyph_code ^ {3'h0, glyph_line}) : 7'h00;
endmodule

// ===== tb/crvse_bench.sv
// Self-checking bench for the video scroll engine
`timescale 1ns/10ps
module crvse_bench;
  logic       core_clk, sys_rst, horiz_active, vert_active_n;       // Clock and timing
  logic       flash_option_switch, reverse_video_switch, ext_blank; // Options
  logic       scroll_port_wr_n, scroll_port_rd_n, cpu_data_oe;      // Port strobes
  logic [7:0] cpu_data_in, cpu_data_out, mem_word;                  // Buses
  logic [5:0] char_addr, cursor_pos;                                // Positions
  logic [3:0] row_addr, glyph_line;                                 // Row and line
  logic [6:0] glyph_code, glyph_dots;                               // Glyph lookup
  logic       load_strobe, serial_dot_out, video_out, shade_blank;  // Video
  logic       oe_q, saw_run, lit;                                   // Monitor state
  int         n_errors, comparisons;                                // Counts
  logic       exp_q[$];                                             // Expected status

  crvse_top #(.PACE_CYCLES(100), .FLASH_CYCLES(50)) dut (
    .core_clk(core_clk), .sys_rst(sys_rst), .horiz_active(horiz_active),
    .vert_active_n(vert_active_n), .flash_option_switch(flash_option_switch),
    .reverse_video_switch(reverse_video_switch), .ext_blank(ext_blank),
    .scroll_port_wr_n(scroll_port_wr_n), .scroll_port_rd_n(scroll_port_rd_n),
    .cpu_data_in(cpu_data_in), .cpu_data_out(cpu_data_out), .cpu_data_oe(cpu_data_oe),
    .char_addr(char_addr), .row_addr(row_addr), .mem_word(mem_word),
    .glyph_code(glyph_code), .glyph_line(glyph_line), .glyph_dots(glyph_dots),
    .load_strobe(load_strobe), .serial_dot_out(serial_dot_out), .video_out(video_out),
    .shade_blank(shade_blank));
  crvse_mem_model u_mem (.char_addr(char_addr), .row_addr(row_addr),
    .glyph_code(glyph_code), .glyph_line(glyph_line), .cursor_pos(cursor_pos),
    .mem_word(mem_word), .glyph_dots(glyph_dots));

  // ****************************************************************
  // Clock, tasks and monitors
  // ****************************************************************
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  task automatic chk(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR at %0t: got %b expected %b", $time, got, exp);
    end
  endtask
  task automatic end_sim;
    $display("comparisons %0d n_errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Port write: data settles one edge ahead, strobe held four edges
  task automatic port_wr(input logic [7:0] d);
    cpu_data_in <= d;
    @(posedge core_clk);
    scroll_port_wr_n <= 1'b0;
    repeat (4) @(posedge core_clk);
    scroll_port_wr_n <= 1'b1;
    repeat (3) @(posedge core_clk);
  endtask
  // Status poll: expectation noted, strobe held four edges
  task automatic port_rd(input logic e);
    exp_q.push_back(e);
    scroll_port_rd_n <= 1'b0;
    repeat (4) @(posedge core_clk);
    scroll_port_rd_n <= 1'b1;
    repeat (3) @(posedge core_clk);
  endtask
  task automatic scan_line;
    horiz_active <= 1'b1;
    repeat (72) @(posedge core_clk);
    horiz_active <= 1'b0;
    repeat (40) @(posedge core_clk);
  endtask
  // Frame of whole rows, then two blank lines with presets back
  task automatic frame(input int rows, input logic run, input logic on, input logic [3:0] r0);
    saw_run = 1'b0;
    lit = 1'b0;
    vert_active_n <= 1'b0;
    repeat (rows * 13) scan_line();
    vert_active_n <= 1'b1;
    repeat (2) scan_line();
    chk(saw_run, run);
    chk(lit, on);
    chk(row_addr == r0, 1'b1);
  endtask
  // Status results taken off the queue as the bus enable rises
  always @(negedge core_clk) begin
    if (cpu_data_oe === 1'b1 && oe_q !== 1'b1) begin
      chk(exp_q.size() != 0, 1'b1);
      if (exp_q.size() != 0) begin
        chk(cpu_data_out[0], exp_q.pop_front());
      end
    end
    oe_q = cpu_data_oe;
    if (!vert_active_n && shade_blank === 1'b0) begin
      saw_run = 1'b1;
    end
    if (!vert_active_n && video_out === 1'b1) begin
      lit = 1'b1;
    end
  end
  initial begin
    repeat (80000) @(posedge core_clk);
    n_errors++;
    end_sim();
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    logic [7:0] d; // Random write value
    {horiz_active, flash_option_switch, reverse_video_switch, ext_blank} = 4'h0;
    {vert_active_n, scroll_port_wr_n, scroll_port_rd_n, sys_rst} = 4'hF;
    {cpu_data_in, cursor_pos, n_errors, comparisons, oe_q} = '0;
    void'($urandom(32'hD73B3DF3));
    repeat (4) @(posedge core_clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge core_clk);
    port_rd(1'b0);
    d = 8'($urandom()) & 8'h0F;
    port_wr(d);
    port_rd(1'b1);
    frame(1, 1'b1, 1'b1, d[3:0]);
    port_rd(1'b0);
    port_wr(8'h1F);
    repeat (60) @(posedge core_clk);
    port_wr(8'h1F);
    repeat (60) @(posedge core_clk);
    port_rd(1'b1);
    frame(3, 1'b1, 1'b1, 4'hF);
    d = 8'($urandom()) | 8'hF0;
    port_wr(d);
    frame(3, 1'b0, 1'b0, d[3:0]);
    port_wr(8'h02);
    ext_blank <= 1'b1;
    repeat (40) @(posedge core_clk);
    frame(1, 1'b1, 1'b0, 4'h2);
    ext_blank <= 1'b0;
    flash_option_switch <= 1'b1;
    cursor_pos <= 6'($urandom());
    frame(1, 1'b1, 1'b1, 4'h2);
    reverse_video_switch <= 1'b1;
    repeat (60) @(posedge core_clk);
    chk(video_out, 1'b1);
    reverse_video_switch <= 1'b0;
    repeat (60) @(posedge core_clk);
    chk(video_out, 1'b0);
    end_sim();
  end
endmodule
